// ==== lcb_defs.svh ====
// constants for the logic, compare and decimal adjust execution block
`ifndef LCB_DEFS_SVH
`define LCB_DEFS_SVH

`define LCB_OP_ANL_A_DIR 8'h55
`define LCB_OP_ANL_A_IMM 8'h54
`define LCB_OP_ANL_DIR_A 8'h52
`define LCB_OP_ANL_DIR_IMM 8'h53
`define LCB_OP_ANL_C_BIT 8'h82
`define LCB_OP_ANL_C_NBIT 8'hb0
`define LCB_OP_COMPARE_JUMP_UNEQUAL_A_DIR 8'hb5
`define LCB_OP_COMPARE_JUMP_UNEQUAL_A_IMM 8'hb4
`define LCB_OP_CLR_A 8'he4
`define LCB_OP_CLR_C 8'hc3
`define LCB_OP_CLR_BIT 8'hc2
`define LCB_OP_CPL_A 8'hf4
`define LCB_OP_CPL_C 8'hb3
`define LCB_OP_CPL_BIT 8'hb2
`define LCB_OP_DA 8'hd4
// upper opcode fields of register and pointer forms
`define LCB_HI5_ANL_A_RN 5'h0b
`define LCB_HI5_COMPARE_JUMP_UNEQUAL_RN 5'h17
`define LCB_HI7_ANL_A_IND 7'h2b
`define LCB_HI7_COMPARE_JUMP_UNEQUAL_IND 7'h5b

`define LCB_BIT_RAM_NIB 4'h2
`define LCB_ACC_RST 8'h00
`define LCB_PC_RST 16'h0000
`define LCB_DA_LO_ADD 9'h006
`define LCB_DA_HI_ADD 9'h060
`define LCB_NIBBLE_MAX 4'h9
`define LCB_LEN_COMPARE_JUMP_UNEQUAL 2'h3

`endif

// ==== lcb_pkg.sv ====
// types shared by the execution block
`default_nettype none
package lcb_pkg;
    typedef enum logic [2:0] {
        LCB_IDLE = 3'b000,
        LCB_PTRA = 3'b001,
        LCB_PTRD = 3'b010,
        LCB_OPRA = 3'b011,
        LCB_OPRD = 3'b100,
        LCB_EXEC = 3'b101
    } lcb_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic latch;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lcb_mem_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } lcb_flags_t;
endpackage : lcb_pkg
`default_nettype wire

// ==== lcb_dadj.sv ====
// decimal adjust of the accumulator after a packed bcd addition
`include "lcb_defs.svh"
`default_nettype none
module lcb_dadj (
    input wire logic [7:0] acc,
    input wire logic cy,
    input wire logic ac,
    output logic [7:0] result,
    output logic cy_out
);
    logic lo_adj;
    logic hi_adj;
    logic c1;
    logic [8:0] t1;
    logic [8:0] t2;

    always_comb
    begin
        lo_adj = (acc[3:0] > `LCB_NIBBLE_MAX) || ac;
        t1 = {1'b0, acc} + (lo_adj ? `LCB_DA_LO_ADD : 9'h000);
        c1 = cy | t1[8];
        hi_adj = c1 || (t1[7:4] > `LCB_NIBBLE_MAX);
        t2 = {1'b0, t1[7:0]} + (hi_adj ? `LCB_DA_HI_ADD : 9'h000);
        // net effect of one of four constants
        result = t2[7:0];
        cy_out = c1 | t2[8];
    end
endmodule : lcb_dadj
`default_nettype wire

// ==== lcb_branch.sv ====
// next program counter and unsigned compare for the execute step
`default_nettype none
module lcb_branch (
    input wire logic [15:0] pc,
    input wire logic [1:0] len,
    input wire logic [7:0] rel,
    input wire logic [7:0] lhs,
    input wire logic [7:0] rhs,
    input wire logic is_cmp,
    output logic [15:0] pc_next,
    output logic less
);
    logic [15:0] pc_seq;

    always_comb
    begin
        pc_seq = pc + {14'h0000, len};
        less = lhs < rhs;
        if (is_cmp && (lhs != rhs))
            pc_next = pc_seq + {{8{rel[7]}}, rel};
        else
            pc_next = pc_seq;
    end
endmodule : lcb_branch
`default_nettype wire

// ==== lcb_exec.sv ====
// execution datapath: byte and bit and, compare-branch, clear, complement, decimal adjust
`include "lcb_defs.svh"
`default_nettype none
module lcb_exec (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic START,
    input wire logic [7:0] OPCODE,
    input wire logic [7:0] OPERAND1,
    input wire logic [7:0] OPERAND2,
    input wire logic [15:0] PC_IN,
    input wire logic [1:0] BANK,
    input wire logic ADD_REQ,
    input wire logic ADD_WITH_CARRY,
    input wire logic [7:0] ADD_DATA,
    output lcb_pkg::lcb_mem_t MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [15:0] PC_OUT,
    output logic [7:0] ACC,
    output lcb_pkg::lcb_flags_t FLAGS,
    output logic PARITY
);
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        bit_byte = b[7] ? {b[7:3], 3'h0} : {`LCB_BIT_RAM_NIB, b[6:3]};
    endfunction : bit_byte

    function automatic logic uses_ptr(input logic [7:0] op);
        uses_ptr = (op[7:1] == `LCB_HI7_ANL_A_IND) || (op[7:1] == `LCB_HI7_COMPARE_JUMP_UNEQUAL_IND);
    endfunction : uses_ptr

    function automatic logic uses_rn(input logic [7:0] op);
        uses_rn = (op[7:3] == `LCB_HI5_ANL_A_RN) || (op[7:3] == `LCB_HI5_COMPARE_JUMP_UNEQUAL_RN);
    endfunction : uses_rn

    function automatic logic is_bitop(input logic [7:0] op);
        is_bitop = (op == `LCB_OP_ANL_C_BIT) || (op == `LCB_OP_ANL_C_NBIT) ||
                   (op == `LCB_OP_CLR_BIT) || (op == `LCB_OP_CPL_BIT);
    endfunction : is_bitop

    function automatic logic is_rmw(input logic [7:0] op);
        is_rmw = (op == `LCB_OP_ANL_DIR_A) || (op == `LCB_OP_ANL_DIR_IMM) ||
                 (op == `LCB_OP_CLR_BIT) || (op == `LCB_OP_CPL_BIT);
    endfunction : is_rmw

    function automatic logic is_compare_jump_unequal(input logic [7:0] op);
        is_compare_jump_unequal = (op == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_DIR) || (op == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_IMM) ||
                  (op[7:3] == `LCB_HI5_COMPARE_JUMP_UNEQUAL_RN) || (op[7:1] == `LCB_HI7_COMPARE_JUMP_UNEQUAL_IND);
    endfunction : is_compare_jump_unequal

    function automatic logic reads_opd(input logic [7:0] op);
        reads_opd = uses_rn(op) || is_bitop(op) || (op == `LCB_OP_ANL_A_DIR) ||
                    (op == `LCB_OP_ANL_DIR_A) || (op == `LCB_OP_ANL_DIR_IMM) ||
                    (op == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_DIR);
    endfunction : reads_opd

    function automatic logic known(input logic [7:0] op);
        known = reads_opd(op) || uses_ptr(op) || is_compare_jump_unequal(op) || (op == `LCB_OP_ANL_A_IMM) ||
                (op == `LCB_OP_CLR_A) || (op == `LCB_OP_CLR_C) || (op == `LCB_OP_CPL_A) ||
                (op == `LCB_OP_CPL_C) || (op == `LCB_OP_DA);
    endfunction : known

    function automatic logic [1:0] op_len(input logic [7:0] op);
        if (is_compare_jump_unequal(op) || (op == `LCB_OP_ANL_DIR_IMM))
            op_len = `LCB_LEN_COMPARE_JUMP_UNEQUAL;
        else if (is_bitop(op) || (op == `LCB_OP_ANL_A_DIR) || (op == `LCB_OP_ANL_A_IMM) ||
                 (op == `LCB_OP_ANL_DIR_A))
            op_len = 2'h2;
        else
            op_len = 2'h1;
    endfunction : op_len

    function automatic logic [7:0] opd_addr(input logic [7:0] op, input logic [7:0] b2, input logic [1:0] bank);
        if (uses_rn(op))
            opd_addr = {3'h0, bank, op[2:0]};
        else if (is_bitop(op))
            opd_addr = bit_byte(b2);
        else
            opd_addr = b2;
    endfunction : opd_addr

    lcb_pkg::lcb_state_t state, next_state;
    logic [7:0] opc, next_opc;
    logic [7:0] b2, next_b2;
    logic [7:0] b3, next_b3;
    logic [15:0] pc, next_pc;
    logic [7:0] opd, next_opd;
    logic [7:0] acc, next_acc;
    lcb_pkg::lcb_flags_t flags, next_flags;
    lcb_pkg::lcb_mem_t mem, next_mem;
    logic done, next_done;
    logic illegal, next_illegal;
    logic [15:0] pc_out, next_pc_out;

    logic bitval;
    logic [7:0] bitmask;
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic less;
    logic [15:0] pc_next;
    logic [7:0] da_res;
    logic da_cy;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [7:0] sum_c6;
    logic cin;

    lcb_dadj u_dadj (
        .acc(acc),
        .cy(flags.cy),
        .ac(flags.ac),
        .result(da_res),
        .cy_out(da_cy)
    );

    lcb_branch u_branch (
        .pc(pc),
        .len(op_len(opc)),
        .rel(b3),
        .lhs(lhs),
        .rhs(rhs),
        .is_cmp(is_compare_jump_unequal(opc)),
        .pc_next(pc_next),
        .less(less)
    );

    always_comb
    begin
        bitval = opd[b2[2:0]];
        bitmask = 8'h01 << b2[2:0];
        // accumulator forms compare acc, others the fetched byte
        lhs = ((opc == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_DIR) || (opc == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_IMM)) ? acc : opd;
        rhs = (opc == `LCB_OP_COMPARE_JUMP_UNEQUAL_A_DIR) ? opd : b2;
        cin = ADD_WITH_CARRY & flags.cy;
        sum9 = {1'b0, acc} + {1'b0, ADD_DATA} + {8'h00, cin};
        sum_lo = {1'b0, acc[3:0]} + {1'b0, ADD_DATA[3:0]} + {4'h0, cin};
        sum_c6 = {1'b0, acc[6:0]} + {1'b0, ADD_DATA[6:0]} + {7'h00, cin};
    end

    always_comb
    begin
        next_state = state;
        next_opc = opc;
        next_b2 = b2;
        next_b3 = b3;
        next_pc = pc;
        next_opd = opd;
        next_acc = acc;
        next_flags = flags;
        next_mem = '0;
        next_done = 1'b0;
        next_illegal = 1'b0;
        next_pc_out = pc_out;
        case (state)
            lcb_pkg::LCB_IDLE:
            begin
                if (START)
                begin
                    next_opc = OPCODE;
                    next_b2 = OPERAND1;
                    next_b3 = OPERAND2;
                    next_pc = PC_IN;
                    // pointer read from the selected bank
                    if (uses_ptr(OPCODE))
                    begin
                        next_mem.rd = 1'b1;
                        next_mem.addr = {3'h0, BANK, 2'h0, OPCODE[0]};
                        next_state = lcb_pkg::LCB_PTRA;
                    end
                    else if (reads_opd(OPCODE))
                    begin
                        next_mem.rd = 1'b1;
                        next_mem.addr = opd_addr(OPCODE, OPERAND1, BANK);
                        next_mem.latch = is_rmw(OPCODE);
                        next_state = lcb_pkg::LCB_OPRA;
                    end
                    else
                        next_state = lcb_pkg::LCB_EXEC;
                end
                else if (ADD_REQ)
                begin
                    // add updates carry, aux carry and overflow
                    next_acc = sum9[7:0];
                    next_flags.cy = sum9[8];
                    next_flags.ac = sum_lo[4];
                    next_flags.ov = sum9[8] ^ sum_c6[7];
                end
            end
            lcb_pkg::LCB_PTRA:
                next_state = lcb_pkg::LCB_PTRD;
            lcb_pkg::LCB_PTRD:
            begin
                next_mem.rd = 1'b1;
                next_mem.addr = MEM_RDATA;
                next_state = lcb_pkg::LCB_OPRA;
            end
            lcb_pkg::LCB_OPRA:
                next_state = lcb_pkg::LCB_OPRD;
            lcb_pkg::LCB_OPRD:
            begin
                next_opd = MEM_RDATA;
                next_state = lcb_pkg::LCB_EXEC;
            end
            lcb_pkg::LCB_EXEC:
            begin
                next_done = 1'b1;
                next_illegal = !known(opc);
                next_pc_out = pc_next;
                next_state = lcb_pkg::LCB_IDLE;
                if ((opc == `LCB_OP_ANL_A_DIR) || (opc[7:3] == `LCB_HI5_ANL_A_RN) ||
                    (opc[7:1] == `LCB_HI7_ANL_A_IND))
                    next_acc = acc & opd;
                else if (opc == `LCB_OP_ANL_A_IMM)
                    next_acc = acc & b2;
                else if ((opc == `LCB_OP_ANL_DIR_A) || (opc == `LCB_OP_ANL_DIR_IMM))
                begin
                    // result back to the direct byte
                    next_mem.wr = 1'b1;
                    next_mem.addr = b2;
                    next_mem.wdata = opd & ((opc == `LCB_OP_ANL_DIR_A) ? acc : b3);
                end
                else if (opc == `LCB_OP_ANL_C_BIT)
                begin
                    if (!bitval)
                        next_flags.cy = 1'b0;
                end
                else if (opc == `LCB_OP_ANL_C_NBIT)
                begin
                    if (bitval)
                        next_flags.cy = 1'b0;
                end
                else if (is_compare_jump_unequal(opc))
                    next_flags.cy = less;
                else if (opc == `LCB_OP_CLR_A)
                    next_acc = `LCB_ACC_RST;
                else if (opc == `LCB_OP_CPL_A)
                    next_acc = ~acc;
                else if (opc == `LCB_OP_CLR_C)
                    next_flags.cy = 1'b0;
                else if (opc == `LCB_OP_CPL_C)
                    next_flags.cy = ~flags.cy;
                else if ((opc == `LCB_OP_CLR_BIT) || (opc == `LCB_OP_CPL_BIT))
                begin
                    next_mem.wr = 1'b1;
                    next_mem.addr = bit_byte(b2);
                    next_mem.wdata = (opc == `LCB_OP_CLR_BIT) ? (opd & ~bitmask) : (opd ^ bitmask);
                end
                else if (opc == `LCB_OP_DA)
                begin
                    // carry only ever set, overflow kept
                    next_acc = da_res;
                    next_flags.cy = da_cy;
                end
            end
            default:
                next_state = lcb_pkg::LCB_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state <= lcb_pkg::LCB_IDLE;
            opc <= 8'h00;
            b2 <= 8'h00;
            b3 <= 8'h00;
            pc <= `LCB_PC_RST;
            opd <= 8'h00;
            acc <= `LCB_ACC_RST;
            flags <= '0;
            mem <= '0;
            done <= 1'b0;
            illegal <= 1'b0;
            pc_out <= `LCB_PC_RST;
            PARITY <= 1'b0;
        end
        else
        begin
            state <= next_state;
            opc <= next_opc;
            b2 <= next_b2;
            b3 <= next_b3;
            pc <= next_pc;
            opd <= next_opd;
            acc <= next_acc;
            flags <= next_flags;
            mem <= next_mem;
            done <= next_done;
            illegal <= next_illegal;
            pc_out <= next_pc_out;
            PARITY <= ^next_acc;
        end
    end

    assign MEM_REQ = mem;
    assign BUSY = (state != lcb_pkg::LCB_IDLE);
    assign DONE = done;
    assign ILLEGAL = illegal;
    assign PC_OUT = pc_out;
    assign ACC = acc;
    assign FLAGS = flags;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic exec;
    assign exec = (state == lcb_pkg::LCB_EXEC);

    clr_acc_a: assert property (exec && opc == `LCB_OP_CLR_A |=> ACC == 8'h00 && FLAGS == $past(flags))
        else $error("clear did not zero accumulator");
    cpl_acc_a: assert property (exec && opc == `LCB_OP_CPL_A |=> ACC == ~$past(acc))
        else $error("complement result wrong");
    anl_carry_a: assert property (exec && opc == `LCB_OP_ANL_C_NBIT && bitval |=> !FLAGS.cy && !MEM_REQ.wr)
        else $error("inverted bit and wrong");
    compare_jump_unequal_carry_a: assert property (exec && is_compare_jump_unequal(opc) |=> FLAGS.cy == ($past(lhs) < $past(rhs)))
        else $error("compare carry wrong");
    compare_jump_unequal_pc_a: assert property (exec && is_compare_jump_unequal(opc) && lhs == rhs |=> PC_OUT == $past(pc) + 16'h0003)
        else $error("equal compare branched");
    da_carry_a: assert property (exec && opc == `LCB_OP_DA && flags.cy |=> FLAGS.cy && FLAGS.ov == $past(flags.ov))
        else $error("decimal adjust cleared carry or changed overflow");
    parity_track_a: assert property (PARITY == ^ACC)
        else $error("parity does not match accumulator");
    rmw_latch_a: assert property (MEM_REQ.rd && is_rmw(opc) && state == lcb_pkg::LCB_OPRA |-> MEM_REQ.latch)
        else $error("read-modify-write not from latch");
    done_bound_a: assert property (START && !BUSY |=> BUSY ##[1:5] DONE)
        else $error("instruction did not complete");

    cover_compare_jump_unequal_taken: cover property (exec && is_compare_jump_unequal(opc) && lhs != rhs);
    cover_da_both: cover property (exec && opc == `LCB_OP_DA && da_res != acc && da_cy);
    cover_cpl_bit: cover property (exec && opc == `LCB_OP_CPL_BIT);
endmodule : lcb_exec
`default_nettype wire

// ==== lcb_mem_model.sv ====
// internal ram and port latch model on the far side of the execution block
`default_nettype none
module lcb_mem_model (
    input wire logic clk,
    input wire lcb_pkg::lcb_mem_t req,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] PORT_ADDR = 8'h90;
    logic [7:0] mem [256];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'h00;
        rdata = 8'h00;
    end
    always @(posedge clk)
    begin
        if (req.rd)
            rdata <= (req.addr == PORT_ADDR && !req.latch) ? ~mem[req.addr] : mem[req.addr];
        else
            rdata <= ~rdata;
        if (req.wr)
            mem[req.addr] <= req.wdata;
    end
endmodule : lcb_mem_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the logic, compare and decimal adjust block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] bank;
        logic [7:0] acc;
        logic cy;
        logic [7:0] op;
        logic [7:0] o1;
        logic [7:0] o2;
        logic [7:0] eacc;
        logic ecy;
        logic [15:0] poff;
        logic [7:0] maddr;
        logic [7:0] mval;
    } lcb_row_t;
    localparam logic [15:0] PC_BASE = 16'hfff8;
    logic CLK = 1'h0;
    logic RST_N, START, ADD_REQ, ADD_WITH_CARRY, BUSY, DONE, ILLEGAL, PARITY;
    logic [7:0] OPCODE, OPERAND1, OPERAND2, ADD_DATA, MEM_RDATA, ACC;
    logic [15:0] PC_IN, PC_OUT;
    logic [1:0] BANK;
    lcb_pkg::lcb_mem_t MEM_REQ;
    lcb_pkg::lcb_flags_t FLAGS;
    int failures = 0;
    int tests_run = 0;
    lcb_row_t rows [21] = '{
        '{2'h0, 8'hc3, 1'h0, 8'h55, 8'h30, 8'h00, 8'h03, 1'h0, 16'h0002, 8'h30, 8'h0f},
        '{2'h0, 8'hc3, 1'h0, 8'h56, 8'h00, 8'h00, 8'h00, 1'h0, 16'h0001, 8'h40, 8'h3c},
        '{2'h0, 8'hc3, 1'h0, 8'h54, 8'haa, 8'h00, 8'h82, 1'h0, 16'h0002, 8'h30, 8'h0f},
        '{2'h0, 8'h5c, 1'h1, 8'he4, 8'h00, 8'h00, 8'h00, 1'h1, 16'h0001, 8'h30, 8'h0f},
        '{2'h0, 8'h5c, 1'h1, 8'hf4, 8'h00, 8'h00, 8'ha3, 1'h1, 16'h0001, 8'h30, 8'h0f},
        '{2'h0, 8'h00, 1'h1, 8'hc3, 8'h00, 8'h00, 8'h00, 1'h0, 16'h0001, 8'h30, 8'h0f},
        '{2'h0, 8'h00, 1'h0, 8'hb3, 8'h00, 8'h00, 8'h00, 1'h1, 16'h0001, 8'h30, 8'h0f},
        '{2'h0, 8'h00, 1'h1, 8'h82, 8'h08, 8'h00, 8'h00, 1'h1, 16'h0002, 8'h21, 8'h01},
        '{2'h0, 8'h00, 1'h1, 8'h82, 8'h09, 8'h00, 8'h00, 1'h0, 16'h0002, 8'h21, 8'h01},
        '{2'h0, 8'h00, 1'h1, 8'hb0, 8'h08, 8'h00, 8'h00, 1'h0, 16'h0002, 8'h21, 8'h01},
        '{2'h0, 8'h34, 1'h0, 8'hb4, 8'h60, 8'h10, 8'h34, 1'h1, 16'h0013, 8'h30, 8'h0f},
        '{2'h0, 8'h34, 1'h1, 8'hb4, 8'h34, 8'h10, 8'h34, 1'h0, 16'h0003, 8'h30, 8'h0f},
        '{2'h0, 8'h34, 1'h0, 8'hb5, 8'h30, 8'hf0, 8'h34, 1'h0, 16'hfff3, 8'h30, 8'h0f},
        '{2'h1, 8'h34, 1'h0, 8'hbf, 8'h60, 8'h80, 8'h34, 1'h1, 16'hff83, 8'h0f, 8'h56},
        '{2'h0, 8'h34, 1'h0, 8'hb6, 8'h3c, 8'h05, 8'h34, 1'h0, 16'h0003, 8'h40, 8'h3c},
        '{2'h0, 8'hc3, 1'h0, 8'h52, 8'h30, 8'h00, 8'hc3, 1'h0, 16'h0002, 8'h30, 8'h03},
        '{2'h0, 8'hc3, 1'h0, 8'h53, 8'h90, 8'h73, 8'hc3, 1'h0, 16'h0003, 8'h90, 8'h51},
        '{2'h0, 8'hc3, 1'h0, 8'hb2, 8'h91, 8'h00, 8'hc3, 1'h0, 16'h0002, 8'h90, 8'h53},
        '{2'h0, 8'hc3, 1'h0, 8'hc2, 8'h90, 8'h00, 8'hc3, 1'h0, 16'h0002, 8'h90, 8'h52},
        '{2'h1, 8'hc3, 1'h0, 8'h5f, 8'h00, 8'h00, 8'h42, 1'h0, 16'h0001, 8'h0f, 8'h56},
        '{2'h1, 8'hc3, 1'h0, 8'h57, 8'h00, 8'h00, 8'h01, 1'h0, 16'h0001, 8'h21, 8'h01}
    };

    always #50 CLK = ~CLK;

    lcb_exec u_dut (.CLK(CLK), .RST_N(RST_N), .START(START), .OPCODE(OPCODE), .OPERAND1(OPERAND1),
        .OPERAND2(OPERAND2), .PC_IN(PC_IN), .BANK(BANK), .ADD_REQ(ADD_REQ), .ADD_WITH_CARRY(ADD_WITH_CARRY),
        .ADD_DATA(ADD_DATA), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .BUSY(BUSY), .DONE(DONE),
        .ILLEGAL(ILLEGAL), .PC_OUT(PC_OUT), .ACC(ACC), .FLAGS(FLAGS), .PARITY(PARITY));
    lcb_mem_model u_mem (.clk(CLK), .req(MEM_REQ), .rdata(MEM_RDATA));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic chk1(input string what, input logic exp, input logic got);
        chk16(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chk1

    task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
        int n;
        @(negedge CLK);
        START = 1'h1;
        OPCODE = op;
        OPERAND1 = a;
        OPERAND2 = b;
        @(negedge CLK);
        START = 1'h0;
        n = 0;
        while (DONE !== 1'h1 && n < 12)
        begin
            @(negedge CLK);
            n++;
        end
        if (n == 12)
        begin
            chk1("done", 1'h1, DONE);
            end_of_test();
        end
    endtask : run

    task automatic add_acc(input logic [7:0] d, input logic wc);
        @(negedge CLK);
        ADD_REQ = 1'h1;
        ADD_DATA = d;
        ADD_WITH_CARRY = wc;
        @(negedge CLK);
        ADD_REQ = 1'h0;
    endtask : add_acc

    task automatic set_acc(input logic [7:0] v, input logic cy);
        run(8'he4, 8'h00, 8'h00);
        add_acc(v, 1'h0);
        if (cy)
            run(8'hb3, 8'h00, 8'h00);
    endtask : set_acc

    task automatic da_case(input logic [7:0] a, input logic cy, input logic [7:0] b, input logic [7:0] e,
        input logic ecy, input logic eov);
        set_acc(a, cy);
        add_acc(b, cy);
        run(8'hd4, 8'h00, 8'h00);
        chk16("da acc", {8'h00, e}, {8'h00, ACC});
        chk1("da carry", ecy, FLAGS.cy);
        chk1("da wrap", eov, FLAGS.ov);
        chk1("da parity", ^e, PARITY);
        chk16("da pc", PC_BASE + 16'h0001, PC_OUT);
    endtask : da_case

    initial
    begin
        RST_N = 1'h0;
        START = 1'h0;
        OPCODE = 8'h00;
        OPERAND1 = 8'h00;
        OPERAND2 = 8'h00;
        PC_IN = PC_BASE;
        BANK = 2'h0;
        ADD_REQ = 1'h0;
        ADD_WITH_CARRY = 1'h0;
        ADD_DATA = 8'h00;
        repeat (8) @(negedge CLK);
        u_mem.mem[8'h30] = 8'h0f;
        u_mem.mem[8'h00] = 8'h40;
        u_mem.mem[8'h40] = 8'h3c;
        u_mem.mem[8'h07] = 8'h70;
        u_mem.mem[8'h09] = 8'h21;
        u_mem.mem[8'h0f] = 8'h56;
        u_mem.mem[8'h21] = 8'h01;
        u_mem.mem[8'h90] = 8'h5d;
        chk16("reset acc", 16'h0000, {8'h00, ACC});
        chk16("reset pc", 16'h0000, PC_OUT);
        chk1("reset flags", 1'h0, |FLAGS);
        chk1("reset busy", 1'h0, BUSY);
        RST_N = 1'h1;
        $display("test reset done");
        foreach (rows[i])
        begin
            BANK = rows[i].bank;
            set_acc(rows[i].acc, rows[i].cy);
            run(rows[i].op, rows[i].o1, rows[i].o2);
            chk16("acc", {8'h00, rows[i].eacc}, {8'h00, ACC});
            chk1("carry", rows[i].ecy, FLAGS.cy);
            chk1("parity", ^rows[i].eacc, PARITY);
            chk1("legal", 1'h0, ILLEGAL);
            chk16("pc", PC_BASE + rows[i].poff, PC_OUT);
            @(negedge CLK);
            chk16("memory", {8'h00, rows[i].mval}, {8'h00, u_mem.mem[rows[i].maddr]});
        end
        BANK = 2'h0;
        $display("test rows done");
        set_acc(8'hc3, 1'h0);
        add_acc(8'haa, 1'h0);
        chk16("add acc", 16'h006d, {8'h00, ACC});
        chk16("add flags", 16'h0005, {13'h0000, FLAGS});
        da_case(8'h7f, 1'h0, 8'h01, 8'h86, 1'h0, 1'h1);
        da_case(8'h56, 1'h1, 8'h67, 8'h24, 1'h1, 1'h1);
        da_case(8'h30, 1'h0, 8'h99, 8'h29, 1'h1, 1'h0);
        da_case(8'h99, 1'h0, 8'h99, 8'h98, 1'h1, 1'h1);
        da_case(8'h12, 1'h0, 8'h34, 8'h46, 1'h0, 1'h0);
        $display("test decimal adjust done");
        run(8'ha5, 8'h00, 8'h00);
        chk1("illegal", 1'h1, ILLEGAL);
        chk16("illegal pc", PC_BASE + 16'h0001, PC_OUT);
        chk16("illegal acc", 16'h0046, {8'h00, ACC});
        $display("test illegal done");
        set_acc(8'hc3, 1'h0);
        @(negedge CLK);
        START = 1'h1;
        OPCODE = 8'h55;
        OPERAND1 = 8'h30;
        @(negedge CLK);
        OPCODE = 8'he4;
        @(negedge CLK);
        START = 1'h0;
        repeat (2) @(negedge CLK);
        chk1("busy done", 1'h1, DONE);
        chk16("busy acc", 16'h0003, {8'h00, ACC});
        @(negedge CLK);
        chk1("no second done", 1'h0, DONE);
        $display("test busy refusal done");
        @(negedge CLK);
        START = 1'h1;
        OPCODE = 8'h56;
        @(negedge CLK);
        START = 1'h0;
        @(negedge CLK);
        RST_N = 1'h0;
        @(negedge CLK);
        RST_N = 1'h1;
        chk16("rerun acc", 16'h0000, {8'h00, ACC});
        chk1("rerun busy", 1'h0, BUSY);
        chk16("rerun pc", 16'h0000, PC_OUT);
        repeat (8) @(negedge CLK);
        chk1("rerun done", 1'h0, DONE);
        $display("test mid reset done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
